// ### common/pss_pkg.sv
/*
  Constants of the status summary bank: command codes, bit positions, reset values.
  Assumes a protocol engine outside that decodes bus transactions into command strobes.
*/
// Contract
// - Answer code 78h with read-only summary byte.
// - Summary bit 6 shows converter not enabled.
// - Summary bit 5 mirrors voltage status bit 7.
// - Summary bit 4 mirrors current status bit 7.
// - Summary bits ignore writes, clear with sources.
// - Summary bit 2 ORs temperature flags; the code ORs only temperature status bits 7 and 6.
// - Summary bit 1 ORs communication/memory/logic flags.
// - Summary bit 0 covers remaining faults, warnings.
// - Bit 0 reads one after power-up.
// - Code 79h word low byte equals summary.
// - Word bit 15 ORs output voltage flags.
// - Word bit 14 ORs current fault, warning.
// - Word bit 13 ORs input status flags.
// - Word bit 12 shows vendor over-temperature/minimum.
// - Word bit 11 tracks live power-not-good plus the sticky turn-on timeout flag.
// - Power-not-good alerts only when mask clear.
// - Voltage status bits 7,6 on overvoltage.
// - Voltage status bits 5,4 on undervoltage.
// - Voltage status bit 3 on excess setpoint.
// - Voltage flags write-to-clear, each masked.
// - Current status bit 7 on overcurrent.
package pss_pkg;
  localparam int CODE_W = 8;
  localparam int DATA_W = 16;

  localparam logic [7:0] CMD_ALERT_MASK  = 8'h1B;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;

  localparam int SB_OFF   = 6;
  localparam int SB_OVERV = 5;
  localparam int SB_OVERI = 4;
  localparam int SB_TEMP  = 2;
  localparam int SB_COMM  = 1;
  localparam int SB_OTHER = 0;

  localparam int SW_VOLT   = 7;
  localparam int SW_CURR   = 6;
  localparam int SW_INPUT  = 5;
  localparam int SW_VENDOR = 4;
  localparam int SW_PNG    = 3;

  localparam int SV_OV_FAULT = 7;
  localparam int SV_OV_WARN  = 6;
  localparam int SV_UV_WARN  = 5;
  localparam int SV_UV_FAULT = 4;
  localparam int SV_VMAX     = 3;
  localparam int SV_TON      = 2;

  localparam int IO_OC_FAULT = 7;
  localparam int IO_OCW     = 5;
  localparam int IN_LOW     = 3;
  localparam int TMP_OTF    = 7;
  localparam int TMP_OTW    = 6;
  localparam int VND_OTFI   = 7;
  localparam int VND_VMIN   = 1;

  localparam logic [7:0] VOUT_IMPL_BITS = 8'hFC;
  localparam logic [7:0] COMM_ALARM_BITS = 8'hF2;
  localparam logic [7:0] VOUT_STAT_RST  = 8'h00;
  localparam logic [7:0] VOUT_MASK_RST  = 8'h00;
  localparam logic       PNG_MASK_RST   = 1'b1;
  localparam logic       POWERUP_LOW_RST = 1'b1;
endpackage

// ### rtl/pss_sticky_byte.sv
/*
  Byte of sticky status flags: a flag sets on its condition and clears when written with one.
  Assumes set and clear are synchronous to clock; bits outside the implemented mask stay zero.
*/
module pss_sticky_byte #(
  parameter logic [7:0] IMPL_BITS = 8'hFF,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] setCond,
  input  wire logic [7:0] clearBits,
  output logic      [7:0] flags
);
  import pss_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic flag_r;
      logic flag_nxt;
      // A condition present in the clearing cycle keeps the flag set.
      always_comb begin
        flag_nxt = IMPL_BITS[i] & (setCond[i] | (flag_r & ~clearBits[i]));
      end
      always_ff @(posedge clock) begin
        if (rst) begin
          flag_r <= RESET_VAL[i];
        end else begin
          flag_r <= flag_nxt;
        end
      end
      assign flags[i] = flag_r;
    end
  endgenerate
endmodule

// ### rtl/pss_alert_mask.sv
/*
  Alert mask store for the output-voltage flags and the power-not-good condition.
  Assumes the nonvolatile copy is loaded as the reset value; a mask command rewrites it.
*/
module pss_alert_mask (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       maskWrite,
  input  wire logic [7:0] maskTarget,
  input  wire logic [7:0] maskValue,
  output logic      [7:0] voutMask,
  output logic            pngMask
);
  import pss_pkg::*;

  logic [7:0] voutMask_r;
  logic [7:0] voutMask_nxt;
  logic       pngMask_r;
  logic       pngMask_nxt;

  always_comb begin
    voutMask_nxt = voutMask_r;
    pngMask_nxt  = pngMask_r;
    if (maskWrite && maskTarget == CMD_STATUS_VOUT) begin
      voutMask_nxt = maskValue & VOUT_IMPL_BITS;
    end
    if (maskWrite && maskTarget == CMD_STATUS_WORD) begin
      pngMask_nxt = maskValue[SW_PNG];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      voutMask_r <= VOUT_MASK_RST;
      pngMask_r  <= PNG_MASK_RST;
    end else begin
      voutMask_r <= voutMask_nxt;
      pngMask_r  <= pngMask_nxt;
    end
  end

  assign voutMask = voutMask_r;
  assign pngMask  = pngMask_r;
endmodule

// ### rtl/pss_status_bank.sv
/*
  Status summary bank: summary byte, summary word, output-voltage status and alert request.
  Assumes a protocol engine delivers one command per strobe and takes the answer a cycle later;
  the detailed current, input, temperature, communication and vendor bytes arrive as inputs.
*/
module pss_status_bank (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        cmdValid,
  input  wire logic                        cmdWrite,
  input  wire logic [pss_pkg::CODE_W-1:0]  cmdCode,
  input  wire logic [pss_pkg::DATA_W-1:0]  cmdData,
  output logic                             respValid,
  output logic      [pss_pkg::DATA_W-1:0]  respData,
  output logic                             respUnsupported,
  input  wire logic                        converterEnabled,
  input  wire logic                        voutOverFault,
  input  wire logic                        voutOverWarn,
  input  wire logic                        voutUnderWarn,
  input  wire logic                        voutUnderFault,
  input  wire logic                        turnOnTimeout,
  input  wire logic                        voutCmdWrite,
  input  wire logic [15:0]                 voutCmdValue,
  input  wire logic [15:0]                 voutMaxValue,
  input  wire logic [7:0]                  ioutStatus,
  input  wire logic [7:0]                  inputStatus,
  input  wire logic [7:0]                  tempStatus,
  input  wire logic [7:0]                  commStatus,
  input  wire logic [7:0]                  vendorStatus,
  input  wire logic                        vinReachedOn,
  input  wire logic                        vinLowLive,
  input  wire logic                        extAlertPending,
  output logic                             smbAlertOut,
  output logic                             smbAlertOe,
  output logic      [7:0]                  voutStatus
);
  import pss_pkg::*;

  logic [7:0]  voutFlags;
  logic [7:0]  voutMask;
  logic        pngMask;
  logic [7:0]  voutSet;
  logic [7:0]  voutClear;
  logic        maskWrite;
  logic [7:0]  statusByte;
  logic [7:0]  statusHigh;
  logic        powerNotGood;
  logic        alertPending;

  logic        powerUpLow_r;
  logic        powerUpLow_nxt;
  logic        respValid_r;
  logic        respValid_nxt;
  logic [15:0] respData_r;
  logic [15:0] respData_nxt;
  logic        respUnsup_r;
  logic        respUnsup_nxt;
  logic        alertOe_r;
  logic        alertOe_nxt;
  logic [7:0]  voutStatus_r;

  // Conditions that set the sticky output-voltage flags, and clears written by the host.
  always_comb begin
    voutSet          = 8'h00;
    voutSet[SV_OV_FAULT] = voutOverFault;
    voutSet[SV_OV_WARN]  = voutOverWarn;
    voutSet[SV_UV_WARN]  = voutUnderWarn;
    voutSet[SV_UV_FAULT] = voutUnderFault;
    voutSet[SV_VMAX]     = voutCmdWrite && (voutCmdValue > voutMaxValue);
    voutSet[SV_TON]      = turnOnTimeout;
    voutClear = 8'h00;
    if (cmdValid && cmdWrite && cmdCode == CMD_STATUS_VOUT) begin
      voutClear = cmdData[7:0];
    end
    maskWrite = cmdValid && cmdWrite && cmdCode == CMD_ALERT_MASK;
  end

  pss_sticky_byte #(
    .IMPL_BITS (VOUT_IMPL_BITS),
    .RESET_VAL (VOUT_STAT_RST)
  ) u_vout_flags (
    .clock     (clock),
    .rst       (rst),
    .setCond   (voutSet),
    .clearBits (voutClear),
    .flags     (voutFlags)
  );

  pss_alert_mask u_alert_mask (
    .clock      (clock),
    .rst        (rst),
    .maskWrite  (maskWrite),
    .maskTarget (cmdData[7:0]),
    .maskValue  (cmdData[15:8]),
    .voutMask   (voutMask),
    .pngMask    (pngMask)
  );

  // The input-low indication holds from power-up until the input first reaches turn-on.
  always_comb begin
    powerUpLow_nxt = powerUpLow_r & ~vinReachedOn;
  end

  // Summary bits are pure functions of their sources, so no write can reach them.
  always_comb begin
    statusByte           = 8'h00;
    statusByte[SB_OFF]   = ~converterEnabled;
    statusByte[SB_OVERV] = voutFlags[SV_OV_FAULT];
    statusByte[SB_OVERI] = ioutStatus[IO_OC_FAULT];
    statusByte[SB_TEMP]  = tempStatus[TMP_OTF] | tempStatus[TMP_OTW];
    statusByte[SB_COMM]  = |(commStatus & COMM_ALARM_BITS);
    statusByte[SB_OTHER] = voutFlags[SV_OV_WARN] | voutFlags[SV_UV_WARN] | voutFlags[SV_UV_FAULT]
                         | voutFlags[SV_VMAX] | voutFlags[SV_TON] | ioutStatus[IO_OCW]
                         | inputStatus[IN_LOW] | powerUpLow_r;
  end

  always_comb begin
    powerNotGood = voutOverFault | voutOverWarn | voutUnderWarn | voutUnderFault
                 | voutFlags[SV_TON] | tempStatus[TMP_OTF] | tempStatus[TMP_OTW]
                 | ioutStatus[IO_OC_FAULT] | ioutStatus[IO_OCW] | vinLowLive;
    statusHigh            = 8'h00;
    statusHigh[SW_VOLT]   = voutFlags[SV_OV_FAULT] | voutFlags[SV_OV_WARN] | voutFlags[SV_UV_WARN]
                          | voutFlags[SV_UV_FAULT] | voutFlags[SV_VMAX]
                          | voutFlags[SV_TON];
    statusHigh[SW_CURR]   = ioutStatus[IO_OC_FAULT] | ioutStatus[IO_OCW];
    statusHigh[SW_INPUT]  = (|inputStatus) | powerUpLow_r;
    statusHigh[SW_VENDOR] = vendorStatus[VND_OTFI] | vendorStatus[VND_VMIN];
    statusHigh[SW_PNG]    = powerNotGood;
  end

  // The alert stays requested for as long as any unmasked source remains set.
  always_comb begin
    alertPending = (|(voutFlags & ~voutMask))
                 | (powerNotGood & ~pngMask)
                 | extAlertPending;
    alertOe_nxt  = alertPending;
  end

  // Answer decode: reads return data, writes to summaries are accepted and ignored.
  always_comb begin
    respValid_nxt = cmdValid;
    respData_nxt  = 16'h0000;
    respUnsup_nxt = 1'b0;
    if (cmdValid) begin
      case (cmdCode)
        CMD_STATUS_BYTE: begin
          if (!cmdWrite) begin
            respData_nxt = {8'h00, statusByte};
          end
        end
        CMD_STATUS_WORD: begin
          if (!cmdWrite) begin
            respData_nxt = {statusHigh, statusByte};
          end
        end
        CMD_STATUS_VOUT: begin
          if (!cmdWrite) begin
            respData_nxt = {8'h00, voutFlags};
          end
        end
        CMD_ALERT_MASK: begin
          if (!cmdWrite && cmdData[7:0] == CMD_STATUS_VOUT) begin
            respData_nxt = {8'h00, voutMask};
          end else if (!cmdWrite && cmdData[7:0] == CMD_STATUS_WORD) begin
            respData_nxt = {4'h0, pngMask, 3'h0, 8'h00};
          end else if (!cmdWrite) begin
            respUnsup_nxt = 1'b1;
          end
        end
        default: begin
          respUnsup_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      powerUpLow_r <= POWERUP_LOW_RST;
      respValid_r  <= 1'b0;
      respData_r   <= 16'h0000;
      respUnsup_r  <= 1'b0;
      alertOe_r    <= 1'b0;
      voutStatus_r <= VOUT_STAT_RST;
    end else begin
      powerUpLow_r <= powerUpLow_nxt;
      respValid_r  <= respValid_nxt;
      respData_r   <= respData_nxt;
      respUnsup_r  <= respUnsup_nxt;
      alertOe_r    <= alertOe_nxt;
      voutStatus_r <= voutFlags;
    end
  end

  assign respValid       = respValid_r;
  assign respData        = respData_r;
  assign respUnsupported = respUnsup_r;
  assign smbAlertOe      = alertOe_r;
  assign smbAlertOut     = 1'b0;
  assign voutStatus      = voutStatus_r;
endmodule

// ### tb/pss_status_bank_asserts.sv
/*
  Port checks of the status bank, bound to every instance of it.
  Assumes one clock and a synchronous active-high reset.
*/
module pss_status_bank_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cmdValid,
  input wire logic        cmdWrite,
  input wire logic [7:0]  cmdCode,
  input wire logic [15:0] cmdData,
  input wire logic        respValid,
  input wire logic [15:0] respData,
  input wire logic        voutOverFault,
  input wire logic        voutUnderWarn,
  input wire logic        voutCmdWrite,
  input wire logic [15:0] voutCmdValue,
  input wire logic [15:0] voutMaxValue,
  input wire logic [7:0]  ioutStatus,
  input wire logic [7:0]  tempStatus,
  input wire logic        extAlertPending,
  input wire logic        smbAlertOe,
  input wire logic [7:0]  voutStatus
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence rd(c);
    cmdValid && !cmdWrite && cmdCode == c;
  endsequence
  sequence clr7;
    cmdValid && cmdWrite && cmdCode == 8'h7A && cmdData[7] && !voutOverFault;
  endsequence
  resp_latency_a: assert property (respValid == $past(cmdValid))
    else $error("answer strobe not one cycle after command");
  byte_overv_a: assert property (rd(8'h78) |=> respData[5] == voutStatus[7])
    else $error("summary overvoltage bit differs");
  byte_overi_a: assert property (
    rd(8'h78) ##0 $stable(ioutStatus) |=> respData[4] == $past(ioutStatus[7]))
    else $error("summary overcurrent bit differs");
  byte_temp_a: assert property (
    rd(8'h78) ##0 $stable(tempStatus) |=> respData[2] == $past(|tempStatus[7:6]))
    else $error("summary temperature bit differs");
  write_ignored_a: assert property (
    cmdValid && cmdWrite && cmdCode inside {8'h78, 8'h79} |=> respData == 16'h0000)
    else $error("summary write not ignored");
  word_volt_a: assert property (rd(8'h79) |=> respData[15] == |voutStatus[7:2])
    else $error("word voltage bit differs");
  overv_set_a: assert property (voutOverFault |-> ##2 voutStatus[7])
    else $error("overvoltage flag not set");
  underv_set_a: assert property (voutUnderWarn |-> ##2 voutStatus[5])
    else $error("undervoltage warning flag not set");
  vmax_set_a: assert property (
    voutCmdWrite && voutCmdValue > voutMaxValue |-> ##2 voutStatus[3])
    else $error("setpoint excess flag not set");
  overv_clear_a: assert property (clr7 |-> ##2 !voutStatus[7])
    else $error("overvoltage flag not cleared");
  alert_ext_a: assert property (extAlertPending |=> smbAlertOe)
    else $error("alert not raised");
endmodule

bind pss_status_bank pss_status_bank_asserts u_chk (.*);

// ### tb/pss_host_model.sv
/*
  Host model: issues one command per call on the strobe port of the status bank.
  Assumes callers run just after a rising edge of clock.
*/
module pss_host_model (
  input  wire logic        clock,
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [7:0]       cmdCode,
  output logic [15:0]      cmdData,
  input  wire logic        respValid,
  input  wire logic [15:0] respData,
  input  wire logic        respUnsupported
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode  = 8'h00;
    cmdData  = 16'h0000;
  end
  // Clears and mask changes are plain write commands.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic v, output logic [15:0] r, output logic u);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdCode  = c;
    cmdData  = d;
    @(posedge clock);
    #1;
    // The answer stands for the cycle after the taking edge, so it is read here.
    v = respValid;
    r = respData;
    u = respUnsupported;
    // Released lines show the inverse so a late sample cannot match by luck.
    cmdValid = 1'b0;
    cmdWrite = ~w;
    cmdCode  = ~c;
    cmdData  = ~d;
    @(posedge clock);
    #1;
  endtask
endmodule

// ### tb/tb_top.sv
/*
  Self-checking bench of the status bank with a host model on its command port.
  Assumes the host model and checker files are compiled before it.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, cmdValid, cmdWrite, respValid, respUnsupported;
  logic        converterEnabled, voutOverFault, voutOverWarn, voutUnderWarn;
  logic        voutUnderFault, turnOnTimeout, voutCmdWrite, vinReachedOn;
  logic        vinLowLive, extAlertPending, smbAlertOut, smbAlertOe;
  logic [7:0]  cmdCode, ioutStatus, inputStatus, tempStatus, commStatus;
  logic [7:0]  vendorStatus, voutStatus;
  logic [15:0] cmdData, respData, voutCmdValue, voutMaxValue;
  int          n_mismatch = 0;
  int          n_compared = 0;
  pss_status_bank u_dut (.*);
  pss_host_model u_host (.*);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                     input logic [15:0] e, input logic un = 1'b0);
    logic        v, u;
    logic [15:0] r;
    u_host.xfer(w, c, d, v, r, u);
    chk("respValid", 16'h0001, {15'h0, v});
    chk("respUnsupported", {15'h0, un}, {15'h0, u});
    chk("respData", e, r);
  endtask
  task automatic t_powerup;
    cmd(0, 8'h78, 16'h0, 16'h0001);
    cmd(0, 8'h79, 16'h0, 16'h2001);
    vinReachedOn = 1'b1;
    tick;
    vinReachedOn = 1'b0;
    cmd(0, 8'h78, 16'h0, 16'h0000);
    converterEnabled = 1'b0;
    tick;
    cmd(0, 8'h78, 16'h0, 16'h0040);
    converterEnabled = 1'b1;
    cmd(1, 8'h78, 16'hFFFF, 16'h0000);
    cmd(0, 8'h7B, 16'h0, 16'h0000, 1'b1);
  endtask
  task automatic t_vout;
    voutCmdWrite = 1'b1;
    tick;
    voutCmdWrite = 1'b0;
    cmd(0, 8'h7A, 16'h0, 16'h0000);
    voutCmdValue = 16'h0101;
    for (int i = 2; i < 8; i++) begin
      {voutOverFault, voutOverWarn, voutUnderWarn, voutUnderFault, voutCmdWrite,
       turnOnTimeout} = 6'h01 << (i - 2);
      tick;
      {voutOverFault, voutOverWarn, voutUnderWarn, voutUnderFault, voutCmdWrite,
       turnOnTimeout} = 6'h00;
      cmd(0, 8'h7A, 16'h0, 16'h0001 << i);
      cmd(0, 8'h79, 16'h0, i == 7 ? 16'h8020 : i == 2 ? 16'h8801 : 16'h8001);
      chk("smbAlertOe", 16'h0001, {15'h0, smbAlertOe});
      cmd(1, 8'h7A, 16'h00FF, 16'h0000);
      cmd(0, 8'h79, 16'h0, 16'h0000);
      chk("smbAlertOe", 16'h0000, {15'h0, smbAlertOe});
    end
  endtask
  task automatic det(input logic [7:0] io, tp, cm, vd, in, input logic [15:0] e);
    {ioutStatus, tempStatus, commStatus, vendorStatus, inputStatus} = {io, tp, cm, vd, in};
    tick;
    cmd(0, 8'h79, 16'h0, e);
    {ioutStatus, tempStatus, commStatus, vendorStatus, inputStatus} = 40'h0;
  endtask
  task automatic t_mask;
    vinLowLive = 1'b1;
    cmd(0, 8'h79, 16'h0, 16'h0800);
    chk("smbAlertOe", 16'h0000, {15'h0, smbAlertOe});
    cmd(1, 8'h1B, 16'h0079, 16'h0000);
    tick;
    chk("smbAlertOe", 16'h0001, {15'h0, smbAlertOe});
    cmd(1, 8'h1B, 16'h0879, 16'h0000);
    cmd(0, 8'h1B, 16'h0079, 16'h0800);
    vinLowLive = 1'b0;
    cmd(1, 8'h1B, 16'h807A, 16'h0000);
    cmd(0, 8'h1B, 16'h007A, 16'h0080);
    cmd(0, 8'h1B, 16'h0055, 16'h0000, 1'b1);
    voutOverFault = 1'b1;
    tick;
    voutOverFault = 1'b0;
    cmd(0, 8'h78, 16'h0, 16'h0020);
    chk("smbAlertOe", 16'h0000, {15'h0, smbAlertOe});
    cmd(1, 8'h7A, 16'h0080, 16'h0000);
    extAlertPending = 1'b1;
    tick(2);
    chk("smbAlertOe", 16'h0001, {15'h0, smbAlertOe});
    chk("smbAlertOut", 16'h0000, {15'h0, smbAlertOut});
    extAlertPending = 1'b0;
  endtask
  task automatic t_reset;
    cmd(1, 8'h1B, 16'h0079, 16'h0000);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    chk("smbAlertOe", 16'h0000, {15'h0, smbAlertOe});
    cmd(0, 8'h1B, 16'h0079, 16'h0800);
    cmd(0, 8'h78, 16'h0, 16'h0001);
  endtask
  initial begin
    rst = 1'b1;
    converterEnabled = 1'b1;
    {voutOverFault, voutOverWarn, voutUnderWarn, voutUnderFault, turnOnTimeout} = 5'h00;
    {voutCmdWrite, vinReachedOn, vinLowLive, extAlertPending} = 4'h0;
    {ioutStatus, tempStatus, commStatus, vendorStatus, inputStatus} = 40'h0;
    voutCmdValue = 16'h0100;
    voutMaxValue = 16'h0100;
    tick(10);
    rst = 1'b0;
    t_powerup;
    t_vout;
    det(8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 16'h4810);
    det(8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 16'h4801);
    det(8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 16'h0804);
    det(8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 16'h0002);
    det(8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 16'h1000);
    det(8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 16'h2001);
    t_mask;
    t_reset;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    close_out;
  end
endmodule
